// ---- src/sbd_cfg.svh ----
/*
 sdram block decode and timing constants: register offsets, field positions,
 reset values and timing counts in bus clocks.
 assumes inclusion by bare name from the design module.
*/
`ifndef SBD_CFG_SVH
`define SBD_CFG_SVH

// ****************************************
// register byte offsets
// ****************************************
`define SBD_ADDR_CTRL_OFS 12'h000
`define SBD_MASK_OFS 12'h004
`define SBD_REFRESH_OFS 12'h008
`define SBD_STATUS_OFS 12'h00C

// ****************************************
// field positions
// ****************************************
`define SBD_BASE_MSB 31
`define SBD_BASE_LSB 18
`define SBD_REFON_BIT 15
`define SBD_LAT_MSB 13
`define SBD_LAT_LSB 12
`define SBD_ADDR_CTRL_WMASK 32'hFFFC_B000
`define SBD_MASK_WMASK 32'hFFFC_0000
`define SBD_RIC_W 9

// ****************************************
// reset values
// ****************************************
`define SBD_ADDR_CTRL_RST 32'h0000_0000
`define SBD_MASK_RST 32'h0000_0000
`define SBD_RIC_RST 9'h000

// ****************************************
// timing counts in bus clocks, latency 01 then 1x
// ****************************************
`define SBD_RCD_L1 4'h2
`define SBD_RCD_L2 4'h3
`define SBD_CAS_L1 4'h1
`define SBD_CAS_L2 4'h2
`define SBD_RAS_L1 4'h4
`define SBD_RAS_L2 4'h6
`define SBD_RP_L1 4'h2
`define SBD_RP_L2 4'h3
`define SBD_WR_PRE 4'h1
`define SBD_REF_UNIT 16

`endif

// ---- src/sbd_pkg.sv ----
/*
 types for the sdram block decode and timing block.
 assumes sbd_cfg.svh is on the include path.
*/
package sbd_pkg;

    typedef struct packed {
        logic [3:0] row_to_column_delay;
        logic [3:0] column_to_data_delay;
        logic [3:0] active_to_precharge_min;
        logic [3:0] precharge_to_active_min;
        logic [3:0] write_to_precharge;
    } sbd_timing_s;

    typedef struct packed {
        logic hit;
        logic refresh_req;
        logic latency_valid;
    } sbd_status_s;

endpackage

// ---- src/sbd_top.sv ----
/*
 sdram block decode and timing: apb register file for the single sdram block,
 base/mask address hit decode, refresh request timer, latency-derived delays.
 assumes a synchronous apb master on clk and a sequencer that consumes the
 timing outputs and acknowledges refresh requests.
*/
// Function
// - hit when every unmasked base bit 31..18 equals bus address bit
// - refresh requests only while block refresh enable bit 15 is set
// - only column latencies one and two, chosen by bits 13..12
// - latency three is not supported by this controller
// - row to column delay 2 clocks for 01, 3 clocks for 1x
// - read data expected 1 clock after column strobe for 01, 2 for 1x
// - activate to precharge at least 4 clocks for 01, 6 for 1x
// - precharge to activate at least 2 clocks for 01, 3 for 1x
// - one clock from last write data to precharge, all latencies
// - refresh spacing is (interval count + 1) times 16 clocks
`timescale 1ns/1ps
`include "sbd_cfg.svh"

module sbd_top #(
    parameter int ADDR_W = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic refresh_ack,
    output logic block_hit,
    output logic refresh_req,
    output logic block_refresh_on,
    output logic [1:0] column_latency_sel,
    output logic latency_valid,
    output sbd_pkg::sbd_timing_s timing
);

    // ****************************************
    // registers
    // ****************************************
    logic [31:0] sdram_block_addr_ctrl_reg;
    logic [31:0] sdram_block_addr_ctrl_next;
    logic [31:0] block_mask_reg_reg;
    logic [31:0] block_mask_reg_next;
    logic [`SBD_RIC_W-1:0] refresh_interval_count_reg;
    logic [`SBD_RIC_W-1:0] refresh_interval_count_next;
    logic [`SBD_RIC_W+3:0] ref_cnt_reg;
    logic [`SBD_RIC_W+3:0] ref_cnt_next;
    logic refresh_req_reg;
    logic refresh_req_next;
    logic block_hit_reg;
    logic block_hit_next;
    sbd_pkg::sbd_timing_s timing_reg;
    sbd_pkg::sbd_timing_s timing_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pslverr_reg;
    logic pslverr_next;

    logic access;
    logic known;
    logic [`SBD_RIC_W+3:0] ref_period;
    logic [1:0] lat;
    logic refresh_on;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic is_long(input logic [1:0] sel);
        is_long = sel[1];
    endfunction

    function automatic logic lat_defined(input logic [1:0] sel);
        lat_defined = (sel != 2'b00);
    endfunction

    // a set mask bit takes the address bit out of the compare
    function automatic logic bit_matches(input logic addr_bit, input logic base_bit, input logic masked);
        bit_matches = masked || (addr_bit == base_bit);
    endfunction

    // 00 has no timing of its own; the short table keeps the outputs defined
    function automatic sbd_pkg::sbd_timing_s timing_for(input logic [1:0] sel);
        sbd_pkg::sbd_timing_s t;
        if (is_long(sel))
        begin
            t.row_to_column_delay = `SBD_RCD_L2;
            t.column_to_data_delay = `SBD_CAS_L2;
            t.active_to_precharge_min = `SBD_RAS_L2;
            t.precharge_to_active_min = `SBD_RP_L2;
        end
        else
        begin
            t.row_to_column_delay = `SBD_RCD_L1;
            t.column_to_data_delay = `SBD_CAS_L1;
            t.active_to_precharge_min = `SBD_RAS_L1;
            t.precharge_to_active_min = `SBD_RP_L1;
        end
        t.write_to_precharge = `SBD_WR_PRE;
        timing_for = t;
    endfunction

    // terminal count of the refresh timer: period in clocks minus one
    function automatic logic [`SBD_RIC_W+3:0] period_of(input logic [`SBD_RIC_W-1:0] ric);
        period_of = 13'((({4'h0, ric} + 13'h0001) * `SBD_REF_UNIT) - 1);
    endfunction

    // status word: hit, pending refresh, latency defined
    function automatic logic [31:0] status_word(input logic hit, input logic req, input logic valid);
        sbd_pkg::sbd_status_s s;
        s.hit = hit;
        s.refresh_req = req;
        s.latency_valid = valid;
        status_word = {29'h0000_0000, s};
    endfunction

    // ****************************************
    // combinational decodes
    // ****************************************

    assign access = psel & penable;
    assign lat = sdram_block_addr_ctrl_reg[`SBD_LAT_MSB:`SBD_LAT_LSB];
    assign known = (paddr == `SBD_ADDR_CTRL_OFS) || (paddr == `SBD_MASK_OFS) ||
                   (paddr == `SBD_REFRESH_OFS) || (paddr == `SBD_STATUS_OFS);
    assign ref_period = period_of(refresh_interval_count_reg);
    assign refresh_on = sdram_block_addr_ctrl_reg[`SBD_REFON_BIT];

    // ****************************************
    // apb register file
    // ****************************************
    always_comb
    begin
        sdram_block_addr_ctrl_next = sdram_block_addr_ctrl_reg;
        block_mask_reg_next = block_mask_reg_reg;
        refresh_interval_count_next = refresh_interval_count_reg;
        prdata_next = prdata_reg;
        pslverr_next = 1'b0;
        // read data captured in setup, held through the access
        if (psel && !penable)
        begin
            pslverr_next = !known;
            prdata_next = 32'h0000_0000;
            if (!pwrite)
            begin
                unique case (paddr)
                    `SBD_ADDR_CTRL_OFS: prdata_next = sdram_block_addr_ctrl_reg;
                    `SBD_MASK_OFS: prdata_next = block_mask_reg_reg;
                    `SBD_REFRESH_OFS: prdata_next = {23'h00_0000, refresh_interval_count_reg};
                    `SBD_STATUS_OFS: prdata_next = status_word(block_hit_reg, refresh_req_reg, latency_valid);
                    default: prdata_next = 32'h0000_0000;
                endcase
            end
        end
        if (access && pwrite)
        begin
            unique case (paddr)
                // reserved bits 17..16 and 14 kept zero
                `SBD_ADDR_CTRL_OFS: sdram_block_addr_ctrl_next = pwdata & `SBD_ADDR_CTRL_WMASK;
                `SBD_MASK_OFS: block_mask_reg_next = pwdata & `SBD_MASK_WMASK;
                `SBD_REFRESH_OFS: refresh_interval_count_next = pwdata[`SBD_RIC_W-1:0];
                default: ;
            endcase
        end
    end

    // ****************************************
    // apb register file, state
    // ****************************************
    // writes land only at the access edge
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sdram_block_addr_ctrl_reg <= `SBD_ADDR_CTRL_RST;
            block_mask_reg_reg <= `SBD_MASK_RST;
            refresh_interval_count_reg <= `SBD_RIC_RST;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            sdram_block_addr_ctrl_reg <= sdram_block_addr_ctrl_next;
            block_mask_reg_reg <= block_mask_reg_next;
            refresh_interval_count_reg <= refresh_interval_count_next;
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // ****************************************
    // base/mask address decode
    // ****************************************
    // hit follows bus_addr by one clock
    always_comb
    begin
        block_hit_next = 1'b1;
        for (int i = `SBD_BASE_LSB; i <= `SBD_BASE_MSB; i++)
        begin
            if (!bit_matches(bus_addr[i], sdram_block_addr_ctrl_reg[i], block_mask_reg_reg[i]))
            begin
                block_hit_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            block_hit_reg <= 1'b0;
        end
        else
        begin
            block_hit_reg <= block_hit_next;
        end
    end

    // ****************************************
    // refresh request timer
    // ****************************************
    always_comb
    begin
        ref_cnt_next = ref_cnt_reg;
        refresh_req_next = refresh_req_reg;
        if (!refresh_on)
        begin
            // parked while off, so enabling starts a full period
            ref_cnt_next = '0;
            refresh_req_next = 1'b0;
        end
        else
        begin
            if (refresh_ack)
            begin
                refresh_req_next = 1'b0;
            end
            // a new period beats an acknowledge in the same cycle
            if (ref_cnt_reg >= ref_period)
            begin
                ref_cnt_next = '0;
                refresh_req_next = 1'b1;
            end
            else
            begin
                ref_cnt_next = ref_cnt_reg + 13'h0001;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ref_cnt_reg <= '0;
            refresh_req_reg <= 1'b0;
        end
        else
        begin
            ref_cnt_reg <= ref_cnt_next;
            refresh_req_reg <= refresh_req_next;
        end
    end

    // ****************************************
    // latency timing table
    // ****************************************
    // latency 3 has no encoding; only the upper bit picks the long table
    always_comb
    begin
        timing_next = timing_for(lat);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            timing_reg <= '0;
        end
        else
        begin
            timing_reg <= timing_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata = prdata_reg;
    // zero wait states: every access completes in its first cycle
    assign pready = 1'b1;
    assign pslverr = pslverr_reg & access;
    assign block_hit = block_hit_reg;
    assign refresh_req = refresh_req_reg;
    assign block_refresh_on = refresh_on;
    assign column_latency_sel = lat;
    assign latency_valid = lat_defined(lat);
    assign timing = timing_reg;

endmodule // sbd_top

// ---- tb/sbd_chk.sv ----
/* port checker for sbd_top.
 bound to the design from the testbench top. */
`timescale 1ns/1ps
module sbd_chk #(
    parameter int ADDR_W = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic refresh_ack,
    input wire logic block_hit,
    input wire logic refresh_req,
    input wire logic block_refresh_on,
    input wire logic [1:0] column_latency_sel,
    input wire logic latency_valid,
    input wire sbd_pkg::sbd_timing_s timing
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    property p_rcd;
        !rst |=> timing.row_to_column_delay == ($past(column_latency_sel[1]) ? 4'h3 : 4'h2);
    endproperty
    a_rcd: assert property (p_rcd) else $error("row to column delay");
    property p_cas;
        !rst |=> timing.column_to_data_delay == ($past(column_latency_sel[1]) ? 4'h2 : 4'h1);
    endproperty
    a_cas: assert property (p_cas) else $error("column to data delay");
    property p_ras;
        !rst |=> timing.active_to_precharge_min == ($past(column_latency_sel[1]) ? 4'h6 : 4'h4);
    endproperty
    a_ras: assert property (p_ras) else $error("activate to precharge");
    property p_rp;
        !rst |=> timing.precharge_to_active_min == ($past(column_latency_sel[1]) ? 4'h3 : 4'h2);
    endproperty
    a_rp: assert property (p_rp) else $error("precharge to activate");
    property p_wr;
        !rst |=> timing.write_to_precharge == 4'h1;
    endproperty
    a_wr: assert property (p_wr) else $error("write to precharge");
    property p_lat;
        latency_valid == (column_latency_sel != 2'b00);
    endproperty
    a_lat: assert property (p_lat) else $error("latency valid");
    property p_roff;
        !block_refresh_on |=> !refresh_req;
    endproperty
    a_roff: assert property (p_roff) else $error("refresh while off");
    property p_rgap;
        $rose(refresh_req) |=> (!$rose(refresh_req))[*8] ##1 (!$rose(refresh_req))[*7];
    endproperty
    a_rgap: assert property (p_rgap) else $error("refresh spacing");
    property p_rdy;
        pready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("ready low");
    property p_err;
        pslverr |-> psel && penable;
    endproperty
    a_err: assert property (p_err) else $error("error outside access");
    property p_hold;
        refresh_req && !refresh_ack && block_refresh_on |=> refresh_req;
    endproperty
    a_hold: assert property (p_hold) else $error("refresh request dropped");
endmodule // sbd_chk

// ---- tb/sbd_seq_model.sv ----
/* refresh sequencer model: acks a refresh request after ACK_DLY clocks.
 assumes refresh_req is a level held until acknowledged. */
`timescale 1ns/1ps
module sbd_seq_model #(
    parameter int ACK_DLY = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic refresh_req,
    output logic refresh_ack
);
    int n;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            n <= 0;
            refresh_ack <= 1'b0;
        end
        else
        begin
            refresh_ack <= refresh_req && n == ACK_DLY - 1;
            n <= (refresh_req && n < ACK_DLY) ? n + 1 : 0;
        end
    end
endmodule // sbd_seq_model

// ---- tb/testbench.sv ----
/* testbench for sbd_top: registers over apb, decode, latency timing, refresh.
 assumes the design, checker and sequencer model are compiled first. */
`timescale 1ns/1ps
module testbench;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er, rdy;
    logic block_hit, refresh_req, refresh_ack, block_refresh_on, latency_valid;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, bus_addr = '0, prdata, rd;
    logic [1:0] column_latency_sel;
    sbd_pkg::sbd_timing_s timing;
    int bad_count = 0, checks_done = 0, n;
    always #4 clk = ~clk;
    sbd_top dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_addr(bus_addr),
        .refresh_ack(refresh_ack), .block_hit(block_hit), .refresh_req(refresh_req),
        .block_refresh_on(block_refresh_on), .column_latency_sel(column_latency_sel),
        .latency_valid(latency_valid), .timing(timing));
    sbd_seq_model seq_u (.clk(clk), .rst(rst), .refresh_req(refresh_req), .refresh_ack(refresh_ack));
    task automatic tally_and_finish;
    begin
        $display("checks %0d errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
    begin
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            rd = prdata;
            er = pslverr;
            rdy = pready;
            k++;
        end
        while (rdy !== 1'b1 && k < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        if (rdy !== 1'b1)
        begin
            bad_count++;
            tally_and_finish();
        end
    end
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    begin
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    end
    endtask
    task automatic hit(input logic [31:0] a, input logic e);
    begin
        @(posedge clk);
        bus_addr <= a;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(block_hit, e);
    end
    endtask
    task automatic wait_rise(output int c);
    begin
        c = 0;
        do
        begin
            @(negedge clk);
            c++;
        end
        while (refresh_req !== 1'b0 && c < 300);
        do
        begin
            @(negedge clk);
            c++;
        end
        while (refresh_req !== 1'b1 && c < 300);
        if (c >= 300)
        begin
            bad_count++;
            tally_and_finish();
        end
    end
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rchk(12'h000, 32'h0000_0000);
        rchk(12'h004, 32'h0000_0000);
        apb(1'b1, 12'h000, 32'hFFFF_FFFF);
        rchk(12'h000, 32'hFFFC_B000);
        for (int l = 0; l < 4; l++)
        begin
            apb(1'b1, 12'h000, 32'(l) << 12);
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk({12'h000, timing}, l > 1 ? 32'h0003_2631 : 32'h0002_1421);
            chk({31'h0000_0000, latency_valid}, 32'(l != 0));
        end
        apb(1'b1, 12'h000, 32'h0A94_2000);
        hit(32'h0A94_1234, 1'b1);
        hit(32'h0A97_FFFF, 1'b1);
        hit(32'h0A84_1234, 1'b0);
        apb(1'b1, 12'h004, 32'h0010_0000);
        hit(32'h0A84_1234, 1'b1);
        rchk(12'h00C, 32'h0000_0005);
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk({31'h0000_0000, er}, 32'h0000_0001);
        apb(1'b1, 12'h008, 32'h0000_0001);
        rchk(12'h008, 32'h0000_0001);
        apb(1'b1, 12'h000, 32'h0000_A000);
        wait_rise(n);
        wait_rise(n);
        chk(n, 32);
        apb(1'b1, 12'h000, 32'h0000_2000);
        repeat (2) @(posedge clk);
        n = 0;
        repeat (40) @(negedge clk) n += (refresh_req !== 1'b0);
        chk(n, 0);
        tally_and_finish();
    end
endmodule // testbench
bind sbd_top sbd_chk #(.ADDR_W(ADDR_W)) chk_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_addr(bus_addr), .refresh_ack(refresh_ack), .block_hit(block_hit), .refresh_req(refresh_req),
    .block_refresh_on(block_refresh_on), .column_latency_sel(column_latency_sel),
    .latency_valid(latency_valid), .timing(timing));
